// >>> src/lha_hold_track.sv
// running maximum tracker used for max hold and peak hold
`timescale 1ns/1ps
module lha_hold_track
#(
   parameter int W = 12
)
(
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_enable,
   input wire logic i_clear,
   input wire logic i_sample_en,
   input wire logic [W-1:0] i_value,
   output logic [W-1:0] o_held
);

   logic [W-1:0] next_held;
   wire logic restart;
   wire logic bigger;

   // while off or cleared, follow the input so tracking restarts from now
   assign restart = !i_enable || i_clear;
   assign bigger = i_sample_en && (i_value > o_held);
   assign next_held = (restart || bigger) ? i_value : o_held;

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
         o_held <= '0;
      else
         o_held <= next_held;
   end

endmodule

// >>> src/lha_level_ctrl.sv
// level hold and alarm control: max hold, peak hold, threshold alarm
// Overview of operation
// - max hold shows largest level, updates upward
// - held maximum over overload raises indicator
// - hold-clear key restarts max tracking
// - max hold passes backlight, max, clear keys
// - peak hold samples input at 51.2 kHz
// - peak hold switched by menu item 3
// - peak hold shows largest sampled peak
// - held peak over overload raises indicator
// - hold-clear key discards held peak
// - peak only in acceleration; bar keeps characteristic
// - peak hold passes backlight, menu, clear keys
// - alarm on compares level, asserts when exceeded
// - alarm key toggles alarm function
// - threshold 0 to 98 percent, 2 percent steps
// - delay 0 to 9 whole seconds
// - alarm shows indicator and threshold bar segment
// - auto-reset clears output after below-threshold time
// - without auto-reset output latches until cleared
// - hold-clear key clears output at once
// - clears keep function on; toggle off ends
// - alarm blinks value 0.5 s, closes switch, beeps
// - buzzer follows menu item 8 setting
// - menu changes apply on leaving menu screen
`timescale 1ns/1ps
`include "lha_params.svh"
module lha_level_ctrl
   import lha_pkg::*;
#(
   parameter int LW = 12,
   parameter logic [LW-1:0] FULL_SCALE = 12'hfff,
   parameter logic [LW-1:0] OVER_LEVEL = 12'hfff,
   parameter int HALF_S_CYCLES =
      `LHA_CLK_HZ / `LHA_MS_PER_S * `LHA_BLINK_MS
)
(
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire lha_keys_s i_keys,
   input wire logic [LW-1:0] i_level,
   input wire logic i_level_valid,
   input wire logic [LW-1:0] i_sample_mag,
   input wire logic i_mode_accel,
   input wire logic [1:0] i_disp_char,
   input wire logic i_menu_screen,
   input wire lha_cfg_s i_cfg_stage,
   output lha_keys_s o_key_fwd,
   output logic [LW-1:0] o_display_value,
   output lha_ind_s o_ind,
   output logic [1:0] o_bar_char,
   output logic o_bar_thresh_lit,
   output logic [5:0] o_bar_thresh_seg,
   output logic o_alarm_out,
   output logic o_buzzer
);

   localparam int SAMPLE_CYCLES = `LHA_CLK_HZ / `LHA_SAMPLE_HZ;
   localparam int MW = LW + 7;

   // legalise staged settings before they take effect
   function automatic lha_cfg_s clamp_cfg(input lha_cfg_s c);
      lha_cfg_s r;
      r = c;
      if (c.level_pct > `LHA_PCT_MAX)
         r.level_pct = `LHA_PCT_MAX;
      r.level_pct[0] = 1'b0;
      if (c.delay_s > `LHA_DELAY_MAX)
         r.delay_s = `LHA_DELAY_MAX;
      if (c.auto_reset_s > `LHA_AR_MAX)
         r.auto_reset_s = `LHA_AR_MAX;
      return r;
   endfunction

   // key pins come from another domain: two flops, then edge detect
   logic [5:0] key_meta;
   logic [5:0] key_sync;
   logic [5:0] key_prev;

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
      begin
         key_meta <= 6'h00;
         key_sync <= 6'h00;
         key_prev <= 6'h00;
      end
      else
      begin
         key_meta <= i_keys;
         key_sync <= key_meta;
         key_prev <= key_sync;
      end
   end

   // mode state
   lha_cfg_s cfg;
   logic menu_prev;
   logic max_on;
   logic blink;
   lha_alarm_e state;
   lha_alarm_e next_state;
   logic [1:0] bar_char_saved;

   wire logic peak_active;
   wire logic alarm_on;
   wire logic [5:0] allow_mask;
   wire logic [5:0] key_edge;
   wire lha_keys_s press;

   assign peak_active = cfg.peak_on && i_mode_accel;
   assign alarm_on = state != ST_OFF;
   assign key_edge = key_sync & ~key_prev;

   // each active mode narrows the set of live keys
   assign allow_mask = (max_on ? `LHA_KEYS_MAX : `LHA_KEYS_ALL)
      & (peak_active ? `LHA_KEYS_PEAK : `LHA_KEYS_ALL)
      & (alarm_on ? `LHA_KEYS_ALARM : `LHA_KEYS_ALL);
   assign press = key_edge & allow_mask;

   // settings commit only when the menu screen closes
   wire logic menu_exit;
   assign menu_exit = menu_prev && !i_menu_screen;

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
      begin
         menu_prev <= 1'b0;
         cfg <= '{peak_on: `LHA_RST_PEAK_ON, level_pct: `LHA_RST_PCT,
                  delay_s: `LHA_RST_DELAY, auto_reset_on: `LHA_RST_AR_ON,
                  auto_reset_s: `LHA_RST_AR_S, buzzer_on: `LHA_RST_BUZZER};
      end
      else
      begin
         menu_prev <= i_menu_screen;
         if (menu_exit)
            cfg <= clamp_cfg(i_cfg_stage);
      end
   end

   // max hold toggles only from its own key
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
         max_on <= 1'b0;
      else if (press.max_hold)
         max_on <= !max_on;
   end

   // bar keeps the characteristic chosen before peak hold began
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
         bar_char_saved <= 2'h0;
      else if (!peak_active)
         bar_char_saved <= i_disp_char;
   end

   // sample-rate enable for peak hold
   logic [11:0] samp_cnt;
   wire logic samp_en;
   assign samp_en = samp_cnt == 12'(SAMPLE_CYCLES - 1);

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
         samp_cnt <= 12'h000;
      else if (samp_en)
         samp_cnt <= 12'h000;
      else
         samp_cnt <= samp_cnt + 12'h001;
   end

   // half-second tick drives blinking, beeping and both timers
   logic [31:0] half_cnt;
   wire logic half_tick;
   assign half_tick = half_cnt == 32'(HALF_S_CYCLES - 1);

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
      begin
         half_cnt <= 32'h0;
         blink <= 1'b0;
      end
      else
      begin
         half_cnt <= half_tick ? 32'h0 : half_cnt + 32'h1;
         if (!alarm_on)
            blink <= 1'b0;
         else if (half_tick)
            blink <= !blink;
      end
   end

   // hold trackers; clear key restarts them from the present value
   logic [LW-1:0] max_held;
   logic [LW-1:0] peak_held;

   lha_hold_track #(.W(LW)) u_max_hold
   (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      .i_enable(max_on),
      .i_clear(press.hold_clear),
      .i_sample_en(i_level_valid),
      .i_value(i_level),
      .o_held(max_held)
   );

   lha_hold_track #(.W(LW)) u_peak_hold
   (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      .i_enable(peak_active),
      .i_clear(press.hold_clear),
      .i_sample_en(samp_en),
      .i_value(i_sample_mag),
      .o_held(peak_held)
   );

   // threshold compare scaled by 100 to avoid a divider
   wire logic [MW-1:0] level_x100;
   wire logic [MW-1:0] thresh_x100;
   wire logic above;
   assign level_x100 = MW'(i_level) * MW'(`LHA_PCT_FULL);
   assign thresh_x100 = MW'(cfg.level_pct) * MW'(FULL_SCALE);
   assign above = level_x100 > thresh_x100;

   // delay and auto-reset timers run only over unbroken intervals
   wire logic delay_run;
   wire logic ar_run;
   logic delay_done;
   logic ar_done;
   assign delay_run = (state == ST_WATCH) && above;
   assign ar_run = (state == ST_ACTIVE) && !above
                   && cfg.auto_reset_on;

   lha_sec_timer u_delay
   (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      .i_run(delay_run),
      .i_half_tick(half_tick),
      .i_limit_s({3'h0, cfg.delay_s}),
      .o_expired(delay_done)
   );

   lha_sec_timer u_auto_reset
   (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      .i_run(ar_run),
      .i_half_tick(half_tick),
      .i_limit_s(cfg.auto_reset_s),
      .o_expired(ar_done)
   );

   // alarm state: off, watching, output active
   always_comb
   begin
      next_state = state;
      unique case (state)
         ST_OFF:
            if (press.alarm)
               next_state = ST_WATCH;
         ST_WATCH:
            if (press.alarm)
               next_state = ST_OFF;
            else if (delay_done && above && !press.hold_clear)
               next_state = ST_ACTIVE;
         ST_ACTIVE:
            if (press.alarm)
               next_state = ST_OFF;
            else if (press.hold_clear)
               next_state = ST_WATCH;
            else if (ar_done && !above)
               next_state = ST_WATCH;
            // otherwise latched until cleared
      endcase
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
         state <= ST_OFF;
      else
         state <= next_state;
   end

   // display source: peak hold, then max hold, then live level
   wire logic [LW-1:0] next_value;
   wire lha_ind_s next_ind;
   wire logic active;
   assign active = next_state == ST_ACTIVE; // switch, blank, beep agree
   assign next_value = peak_active ? peak_held :
                       max_on ? max_held : i_level;
   assign next_ind.max_hold = max_on;
   assign next_ind.max_over = max_on && (max_held > OVER_LEVEL);
   assign next_ind.peak_hold = peak_active;
   assign next_ind.peak_over = peak_active
                               && (peak_held > OVER_LEVEL);
   assign next_ind.alarm_mode = alarm_on;
   assign next_ind.value_blank = active && blink;

   // registered outputs
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
      begin
         o_key_fwd <= '0;
         o_display_value <= '0;
         o_ind <= '0;
         o_bar_char <= 2'h0;
         o_bar_thresh_lit <= 1'b0;
         o_bar_thresh_seg <= 6'h00;
         o_alarm_out <= 1'b0;
         o_buzzer <= 1'b0;
      end
      else
      begin
         o_key_fwd <= press;
         o_display_value <= next_value;
         o_ind <= next_ind;
         o_bar_char <= peak_active ? bar_char_saved : i_disp_char;
         o_bar_thresh_lit <= alarm_on;
         o_bar_thresh_seg <= cfg.level_pct[6:1];
         o_alarm_out <= active;
         // beeps share the blink phase: half second on, half off
         o_buzzer <= active && cfg.buzzer_on && blink;
      end
   end

endmodule

// >>> src/lha_params.svh
// constants for the level hold and alarm control block
`ifndef LHA_PARAMS_SVH
`define LHA_PARAMS_SVH

// system clock and derived rates
`define LHA_CLK_HZ 125000000
`define LHA_SAMPLE_HZ 51200
`define LHA_BLINK_MS 500
`define LHA_MS_PER_S 1000

// setting limits
`define LHA_PCT_MAX 7'h62
`define LHA_PCT_FULL 7'h64
`define LHA_DELAY_MAX 4'h9
`define LHA_AR_MAX 7'h5a

// bit order of key masks: backlight max_hold hold_clear menu alarm other
`define LHA_KEYS_ALL 6'h3f
`define LHA_KEYS_MAX 6'h38
`define LHA_KEYS_PEAK 6'h2c
`define LHA_KEYS_ALARM 6'h2a

// settings in force after reset
`define LHA_RST_PEAK_ON 1'h0
`define LHA_RST_PCT 7'h32
`define LHA_RST_DELAY 4'h0
`define LHA_RST_AR_ON 1'h0
`define LHA_RST_AR_S 7'h00
`define LHA_RST_BUZZER 1'h1

`endif

// >>> src/lha_pkg.sv
// types shared by the level hold and alarm control block
package lha_pkg;

   typedef enum logic [1:0] {ST_OFF, ST_WATCH, ST_ACTIVE} lha_alarm_e;

   typedef struct packed {
      logic backlight;
      logic max_hold;
      logic hold_clear;
      logic menu;
      logic alarm;
      logic other;
   } lha_keys_s;

   typedef struct packed {
      logic peak_on;
      logic [6:0] level_pct;
      logic [3:0] delay_s;
      logic auto_reset_on;
      logic [6:0] auto_reset_s;
      logic buzzer_on;
   } lha_cfg_s;

   typedef struct packed {
      logic max_hold;
      logic max_over;
      logic peak_hold;
      logic peak_over;
      logic alarm_mode;
      logic value_blank;
   } lha_ind_s;

endpackage

// >>> src/lha_sec_timer.sv
// elapsed-time comparator counting half-second ticks while running
`timescale 1ns/1ps
module lha_sec_timer
(
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_run,
   input wire logic i_half_tick,
   input wire logic [6:0] i_limit_s,
   output logic o_expired
);

   logic [7:0] halves;
   logic [7:0] next_halves;
   wire logic [7:0] limit_halves;
   wire logic reached;

   // stopping the run restarts the count, so only unbroken runs expire
   assign limit_halves = {i_limit_s, 1'b0};
   assign reached = halves >= limit_halves;
   assign next_halves = !i_run ? 8'h00 :
                        (i_half_tick && !reached) ? halves + 8'h01 : halves;

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
      begin
         halves <= 8'h00;
         o_expired <= 1'b0;
      end
      else
      begin
         halves <= next_halves;
         o_expired <= i_run && reached;
      end
   end

endmodule

// >>> tb/lha_level_ctrl_asserts.sv
// port-level checker for the level hold and alarm control block
`timescale 1ns/1ps
module lha_level_ctrl_asserts
   import lha_pkg::*;
#(
   parameter int LW = 12
)
(
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire lha_keys_s o_key_fwd,
   input wire logic [LW-1:0] o_display_value,
   input wire lha_ind_s o_ind,
   input wire logic o_bar_thresh_lit,
   input wire logic [5:0] o_bar_thresh_seg,
   input wire logic o_alarm_out,
   input wire logic o_buzzer
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);

   // a clear key pulse restarts tracking, so skip the cycles around it
   a_display_max: assert property (o_ind.max_hold &&
      $past(o_ind.max_hold, 2) && !(o_key_fwd.hold_clear ||
      $past(o_key_fwd.hold_clear) || $past(o_key_fwd.hold_clear, 2))
      |-> o_display_value >= $past(o_display_value))
      else $error("max hold display went down");
   a_max_refuse: assert property (o_ind.max_hold
      |-> !o_key_fwd.alarm && !o_key_fwd.menu)
      else $error("key passed during max hold");
   a_peak_refuse: assert property (o_ind.peak_hold
      |-> !o_key_fwd.alarm && !o_key_fwd.max_hold)
      else $error("key passed during peak hold");
   a_alarm_refuse: assert property (o_bar_thresh_lit
      |-> !o_key_fwd.max_hold && !o_key_fwd.menu)
      else $error("key passed during alarm");
   a_alarm_key_pulse: assert property (o_key_fwd.alarm
      |=> !o_key_fwd.alarm)
      else $error("alarm key pulse too long");
   a_alarm_needs_on: assert property (!o_bar_thresh_lit
      |-> !o_alarm_out)
      else $error("alarm output with function off");
   a_clear_drops_alarm: assert property (o_key_fwd.hold_clear
      |-> !o_alarm_out)
      else $error("alarm output kept after clear");
   a_buzzer_follows: assert property (o_buzzer
      |-> o_alarm_out && o_ind.value_blank)
      else $error("buzzer without alarm phase");
   a_blank_alarm: assert property (o_ind.value_blank |-> o_alarm_out)
      else $error("blink without alarm");
   a_seg_range: assert property (o_bar_thresh_lit
      |-> o_bar_thresh_seg <= 6'h31)
      else $error("threshold segment out of range");

   // main scenarios
   c_alarm: cover property ($rose(o_alarm_out));
   c_peak_over: cover property (o_ind.peak_over);
   c_max_clear: cover property (o_ind.max_hold && o_key_fwd.hold_clear);
endmodule

bind lha_level_ctrl lha_level_ctrl_asserts #(.LW(LW)) chk_u (
   .i_clk_sys,
   .i_rst_n,
   .o_key_fwd,
   .o_display_value,
   .o_ind,
   .o_bar_thresh_lit,
   .o_bar_thresh_seg,
   .o_alarm_out,
   .o_buzzer
);

// >>> tb/lha_src_model.sv
// measured level source: steady level with a periodic valid pulse
`timescale 1ns/1ps
module lha_src_model
#(
   parameter int LW = 12
)
(
   input wire logic i_clk_sys,
   input wire logic [LW-1:0] i_target,
   output logic [LW-1:0] o_level = '0,
   output logic o_level_valid = 1'h0,
   output logic [LW-1:0] o_sample_mag = '0
);
   logic [1:0] div = 2'h0;

   // new reading every fourth cycle, driven off the sampling edge
   always @(negedge i_clk_sys)
   begin
      div <= div + 2'h1;
      o_level_valid <= (div == 2'h3);
      o_level <= i_target;
      o_sample_mag <= i_target;
   end
endmodule

// >>> tb/tb.sv
// self-checking bench for the level hold and alarm control block
`timescale 1ns/1ps
module tb
   import lha_pkg::*;
();
   localparam lha_keys_s K_MAX = 6'h10;
   localparam lha_keys_s K_CLR = 6'h08;
   localparam lha_keys_s K_ALM = 6'h02;
   logic clk = 1'h0;
   logic rst_n = 1'h0;
   logic [11:0] target = 12'h000;
   lha_keys_s keys = 6'h00;
   lha_cfg_s cfg = 21'h064001;
   logic menu_scr = 1'h0;
   logic accel = 1'h1;
   logic [1:0] dchar = 2'h0;
   logic [11:0] lvl, mag, disp;
   logic lvl_v, lit, alm, buz, b;
   lha_keys_s fwd;
   lha_ind_s ind;
   logic [1:0] bchar;
   logic [5:0] seg;
   int mismatches = 0;
   int n_compared = 0;
   int cycles = 0;

   lha_src_model src_u (.i_clk_sys(clk), .i_target(target), .o_level(lvl),
      .o_level_valid(lvl_v), .o_sample_mag(mag));
   // short half second keeps the timed alarm cases brief
   lha_level_ctrl #(.OVER_LEVEL(12'h800), .HALF_S_CYCLES(8)) dut_u (
      .i_clk_sys(clk), .i_rst_n(rst_n), .i_keys(keys), .i_level(lvl),
      .i_level_valid(lvl_v), .i_sample_mag(mag), .i_mode_accel(accel),
      .i_disp_char(dchar), .i_menu_screen(menu_scr), .i_cfg_stage(cfg),
      .o_key_fwd(fwd), .o_display_value(disp), .o_ind(ind),
      .o_bar_char(bchar), .o_bar_thresh_lit(lit), .o_bar_thresh_seg(seg),
      .o_alarm_out(alm), .o_buzzer(buz));

   // clock and hang guard
   initial
   begin
      forever #4 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         close_out();
      end
   end

   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask

   // keys are levels; hold past the synchroniser, then release
   task automatic press(input lha_keys_s k);
      keys = k;
      tick(6);
      keys = 6'h00;
      tick(6);
   endtask

   // staged values take effect on leaving the menu screen
   task automatic menu(input lha_cfg_s c);
      cfg = c;
      menu_scr = 1'h1;
      tick(2);
      menu_scr = 1'h0;
      tick(4);
   endtask

   function automatic lha_cfg_s mk(input logic p, input logic [6:0] pct,
      input logic [3:0] d, input logic ar, input logic [6:0] s,
      input logic bz);
      return {p, pct, d, ar, s, bz};
   endfunction

   initial
   begin
      tick(4);
      rst_n = 1'h1;
      tick(1);
      chk(alm, 1'h0);
      chk(ind, 6'h00);
      // max hold
      target = 12'h100;
      tick(8);
      press(K_MAX);
      chk(ind.max_hold, 1'h1);
      target = 12'h300;
      tick(8);
      chk(disp, 12'h300);
      target = 12'h200;
      tick(8);
      chk(disp, 12'h300);
      press(K_ALM);
      chk(lit, 1'h0);
      press(K_CLR);
      chk(disp, 12'h200);
      target = 12'h900;
      tick(8);
      chk(ind.max_over, 1'h1);
      target = 12'h100;
      press(K_CLR);
      press(K_MAX);
      chk(ind.max_hold, 1'h0);
      // peak hold
      cfg = mk(1'h1, 7'h32, 4'h0, 1'h0, 7'h00, 1'h1);
      tick(4);
      chk(ind.peak_hold, 1'h0);
      dchar = 2'h2;
      menu(cfg);
      chk(ind.peak_hold, 1'h1);
      dchar = 2'h1;
      tick(4);
      chk(bchar, 2'h2);
      target = 12'h900;
      tick(2600);
      chk(disp, 12'h900);
      chk(ind.peak_over, 1'h1);
      target = 12'h100;
      tick(2600);
      chk(disp, 12'h900);
      press(K_CLR);
      chk(disp, 12'h100);
      press(K_ALM);
      chk(lit, 1'h0);
      accel = 1'h0;
      tick(4);
      chk(ind.peak_hold, 1'h0);
      accel = 1'h1;
      menu(mk(1'h0, 7'h63, 4'h2, 1'h1, 7'h01, 1'h1));
      chk(ind.peak_hold, 1'h0);
      // alarm: 99 percent clamps to 98, delay 2 s, auto reset 1 s
      press(K_ALM);
      chk(lit, 1'h1);
      chk(ind.alarm_mode, 1'h1);
      chk(seg, 6'h31);
      target = 12'hfad;
      tick(80);
      chk(alm, 1'h0);
      target = 12'hfae;
      tick(18);
      target = 12'h100;
      tick(4);
      target = 12'hfae;
      tick(20);
      chk(alm, 1'h0);
      tick(30);
      chk(alm, 1'h1);
      b = ind.value_blank;
      tick(8);
      chk(ind.value_blank, !b);
      chk(buz, !b);
      target = 12'h000;
      tick(4);
      chk(alm, 1'h1);
      // a short rise restarts the auto-reset wait
      target = 12'hfae;
      tick(4);
      target = 12'h000;
      tick(6);
      chk(alm, 1'h1);
      tick(30);
      chk(alm, 1'h0);
      chk(lit, 1'h1);
      // latched alarm, buzzer off, 50 percent
      menu(mk(1'h0, 7'h32, 4'h0, 1'h0, 7'h00, 1'h0));
      chk(seg, 6'h19);
      target = 12'h900;
      tick(10);
      chk(alm, 1'h1);
      chk(buz, 1'h0);
      tick(8);
      chk(buz, 1'h0);
      target = 12'h000;
      tick(60);
      chk(alm, 1'h1);
      press(K_MAX);
      chk(ind.max_hold, 1'h0);
      press(K_CLR);
      chk(alm, 1'h0);
      chk(lit, 1'h1);
      target = 12'h900;
      tick(10);
      chk(alm, 1'h1);
      press(K_ALM);
      chk(alm, 1'h0);
      chk(lit, 1'h0);
      close_out();
   end
endmodule
